// *** src/dma_core_pkg.sv ***
/*
 * Constants, field layouts and carrier types for the four-channel
 * transfer controller core.
 * Assumes a single clock domain and a plain register port on the CPU side.
 */
package dma_core_pkg;

    // ------------------------------------------------------------
    // channel organisation
    // ------------------------------------------------------------
    localparam int NUM_CH = 4;
    localparam int CH_EXT = 2;
    localparam logic [1:0] RELOAD_CH = 2'h2;

    // ------------------------------------------------------------
    // register map (byte offsets)
    // ------------------------------------------------------------
    localparam logic [3:0] OFS_SRC = 4'h0;
    localparam logic [3:0] OFS_DST = 4'h4;
    localparam logic [3:0] OFS_CNT = 4'h8;
    localparam logic [3:0] OFS_CTRL = 4'hC;
    localparam logic [7:0] OFS_OPER = 8'h40;
    localparam logic [1:0] CH_SPACE_TAG = 2'h0;

    // ------------------------------------------------------------
    // field layouts
    // ------------------------------------------------------------
    localparam int CTRL_W = 12;
    localparam int OPER_MASTER = 0;
    localparam int OPER_NMI = 1;
    localparam int OPER_AE = 2;
    localparam logic [1:0] SIZE_BYTE = 2'h0;
    localparam logic [1:0] SIZE_WORD = 2'h1;

    // bit 0 is channel_enable_bit, bit 11 is source_reload_bit
    typedef struct packed {
        logic source_reload_bit;
        logic dst_inc;
        logic src_inc;
        logic [1:0] size;
        logic single_addr;
        logic burst;
        logic edge_detect;
        logic ext_request;
        logic interrupt_enable_bit;
        logic transfer_end_flag;
        logic channel_enable_bit;
    } ctrl_s;

    localparam ctrl_s CTRL_RESET = ctrl_s'(12'h000);
    localparam logic [31:0] ADDR_RESET = 32'h0000_0000;
    localparam logic [31:0] COUNT_RESET = 32'h0000_0000;

    // ------------------------------------------------------------
    // timing counts in clock cycles
    // ------------------------------------------------------------
    localparam int REQ_LATENCY_CLKS = 3;
    localparam logic [1:0] LAT_LOAD = 2'(REQ_LATENCY_CLKS - 2);
    localparam logic [1:0] BUS_LAST = 2'h1;
    localparam int REG_WORD_CLKS = 3;
    localparam int REG_LONG_CLKS = 2 * REG_WORD_CLKS;
    localparam logic [2:0] REG_WORD_LOAD = 3'(REG_WORD_CLKS - 1);
    localparam logic [2:0] REG_LONG_LOAD = 3'(REG_LONG_CLKS - 1);
    localparam logic [1:0] RELOAD_LAST = 2'h3;

    // ------------------------------------------------------------
    // engine states and bus carrier
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_LATENCY,
        ST_DUMMY,
        ST_READ,
        ST_WRITE,
        ST_SINGLE
    } state_e;

    typedef struct packed {
        logic active;
        logic dummy;
        logic wr;
        logic [31:0] addr;
    } dma_bus_s;

endpackage

// *** src/dma_core.sv ***
/*
 * Four-channel transfer controller core: request sampling, dummy cycle
 * insertion, channel-two source reload, ending conditions and CPU access
 * timing of the register space.
 * Assumes request pins synchronous to mclk and a memory bus that completes
 * every cycle in two clocks without wait.
 */
// Added by the designer: the strobed register port and the register addresses.
// How it works
// - single-address level burst inserts one uncounted dummy cycle, no acknowledge, after latency.
// - second sample taken before dummy, at the cycle preceding first real transfer.
// - continued requests add no dummy; sample one bus cycle before next transfer.
// - a resumed single-address level burst gets a fresh dummy cycle.
// - acknowledge covers the same part of each transfer in burst and cycle steal.
// - dual edge burst samples once, starts after three cycles, runs to count end.
// - after NMI or address error, a fresh edge and accept strobe restart transfers.
// - single edge burst samples once, dummy first; resumption strobes once, dummy again.
// - channel two reload restores its programmed source address every four transfers.
// - reload works for byte, word and longword transfer sizes.
// - transfer count drops by one after each completed unit.
// - reload counter clears on enable clear, end flag, NMI, address error, standby.
// - count reaching zero sets end flag; interrupt raised when enabled.
// - clearing channel enable stops the channel without setting end flag.
// - NMI or address error sets global flag, stops all after current unit.
// - dual-address read interrupted by stop still finishes its write.
// - clearing master enable aborts every channel without end flags.
// - each word CPU register access occupies three clocks.
// - longword access is two back-to-back word cycles, six clocks, uninterrupted.
// - single address mode acknowledge spans the whole transfer bus cycle.
// - request pin detected on falling edge or low level as configured.
`timescale 1ns/1ps
`default_nettype none

module dma_core
    import dma_core_pkg::*;
(
    input wire logic mclk, // system clock
    input wire logic rst_n, // async reset, active low
    input wire logic [7:0] reg_addr, // register byte address
    input wire logic [31:0] reg_wdata, // register write data
    input wire logic reg_we, // write strobe
    input wire logic reg_re, // read strobe
    input wire logic reg_long, // access is longword sized
    output logic [31:0] reg_rdata, // read data, cycle after strobe
    output logic cpu_bus_cycle, // register bus cycle in progress
    input wire logic [CH_EXT-1:0] transfer_request_n, // external requests
    output logic [CH_EXT-1:0] transfer_acknowledge, // transfer acknowledge
    output logic [CH_EXT-1:0] request_accepted_strobe, // accept strobe
    input wire logic nmi_event, // nmi pulse
    input wire logic addr_error_event, // address error pulse
    input wire logic standby, // software standby level
    output dma_bus_s dma_bus, // bus cycle driven by the engine
    output logic [NUM_CH-1:0] transfer_end_interrupt // end interrupt requests
);

    // ------------------------------------------------------------
    // storage
    // ------------------------------------------------------------
    logic [31:0] sa [NUM_CH];
    logic [31:0] da [NUM_CH];
    logic [31:0] cnt [NUM_CH];
    ctrl_s ctl [NUM_CH];
    logic [31:0] sa_orig;
    logic master_transfer_enable;
    logic nonmaskable_flag;
    logic address_error_flag;
    logic [1:0] rl_cnt;
    logic [2:0] reg_busy;
    state_e state;
    state_e next_state;
    logic [1:0] act;
    logic [1:0] next_act;
    logic [1:0] cyc;
    logic [1:0] lat;
    logic pend_samp;
    logic use_samp;
    logic [CH_EXT-1:0] req_prev;
    logic [CH_EXT-1:0] edge_pend;

    // ------------------------------------------------------------
    // register decode
    // ------------------------------------------------------------
    wire logic ch_space = (reg_addr[7:6] == CH_SPACE_TAG);
    wire logic [1:0] reg_ch = reg_addr[5:4];
    wire logic [3:0] reg_sel = reg_addr[3:0];
    wire logic oper_wr = reg_we && (reg_addr == OFS_OPER);
    wire ctrl_s wdata_ctrl = ctrl_s'(reg_wdata[CTRL_W-1:0]);
    wire logic [31:0] ch_rd = (reg_sel == OFS_SRC) ? sa[reg_ch] :
                              (reg_sel == OFS_DST) ? da[reg_ch] :
                              (reg_sel == OFS_CNT) ? cnt[reg_ch] :
                              (reg_sel == OFS_CTRL) ? {20'h00000, ctl[reg_ch]} : 32'h0000_0000;
    wire logic [31:0] oper_rd = {29'h0000_0000, address_error_flag,
                                 nonmaskable_flag, master_transfer_enable};
    wire logic [31:0] rd_mux = ch_space ? ch_rd :
                               (reg_addr == OFS_OPER) ? oper_rd : 32'h0000_0000;

    // ------------------------------------------------------------
    // engine decode
    // ------------------------------------------------------------
    logic [NUM_CH-1:0] run_ok;
    logic [NUM_CH-1:0] pending;
    wire ctrl_s act_ctl = ctl[act];
    wire logic act_ext = (act < 2'(CH_EXT)) && act_ctl.ext_request;
    wire logic act_req_low = act_ext && !transfer_request_n[act[0]];
    wire logic bus_st = (state == ST_DUMMY) || (state == ST_READ) ||
                        (state == ST_WRITE) || (state == ST_SINGLE);
    wire logic last_cyc = bus_st && (cyc == BUS_LAST);
    wire logic unit_done = last_cyc && ((state == ST_SINGLE) || (state == ST_WRITE));
    wire logic reload_wrap = unit_done && (act == RELOAD_CH) &&
                             act_ctl.source_reload_bit && (rl_cnt == RELOAD_LAST);
    wire logic abort = !master_transfer_enable || standby;
    wire logic stop_now = nmi_event || addr_error_event || !run_ok[act];
    wire logic more_req = !act_ext || act_ctl.edge_detect || use_samp;
    wire logic keep_going = act_ctl.burst && !stop_now && (cnt[act] != 32'h1) &&
                            !reload_wrap && more_req;
    wire logic any_pend = |pending;
    wire logic [NUM_CH-1:0] te_vec;
    logic [1:0] pick;
    logic accept;

    // ------------------------------------------------------------
    // per-channel registers
    // ------------------------------------------------------------
    for (genvar c = 0; c < NUM_CH; c++) begin : g_ch
        wire logic hit = reg_we && ch_space && (reg_ch == 2'(c));
        wire logic done_here = unit_done && (act == 2'(c));
        wire logic te_set = done_here && (cnt[c] == 32'h1);
        wire logic [31:0] step = (ctl[c].size == SIZE_BYTE) ? 32'h1 :
                                 (ctl[c].size == SIZE_WORD) ? 32'h2 : 32'h4;
        wire logic is_ext = (c < CH_EXT) && ctl[c].ext_request;
        wire logic seen = !is_ext ? 1'b1 :
                          ctl[c].edge_detect ? edge_pend[c % CH_EXT] :
                          !transfer_request_n[c % CH_EXT];
        assign run_ok[c] = master_transfer_enable && !nonmaskable_flag &&
                           !address_error_flag && !standby &&
                           ctl[c].channel_enable_bit && !ctl[c].transfer_end_flag;
        assign pending[c] = run_ok[c] && seen && (cnt[c] != 32'h0);
        assign te_vec[c] = ctl[c].transfer_end_flag;
        assign transfer_end_interrupt[c] = ctl[c].transfer_end_flag &&
                                           ctl[c].interrupt_enable_bit;
        always_ff @(posedge mclk or negedge rst_n) begin
            if (!rst_n) begin
                sa[c] <= ADDR_RESET;
                da[c] <= ADDR_RESET;
                cnt[c] <= COUNT_RESET;
            end else begin
                if (hit && reg_sel == OFS_SRC) begin
                    sa[c] <= reg_wdata;
                end else if (done_here && reload_wrap) begin
                    sa[c] <= sa_orig;
                end else if (done_here && ctl[c].src_inc) begin
                    sa[c] <= sa[c] + step;
                end
                if (hit && reg_sel == OFS_DST) begin
                    da[c] <= reg_wdata;
                end else if (done_here && ctl[c].dst_inc) begin
                    da[c] <= da[c] + step;
                end
                if (hit && reg_sel == OFS_CNT) begin
                    cnt[c] <= reg_wdata;
                end else if (done_here) begin
                    cnt[c] <= cnt[c] - 32'h1;
                end
            end
        end
        // end flag: hardware set wins over a software clear
        always_ff @(posedge mclk or negedge rst_n) begin
            if (!rst_n) begin
                ctl[c] <= CTRL_RESET;
            end else if (hit && reg_sel == OFS_CTRL) begin
                ctl[c] <= wdata_ctrl;
                ctl[c].source_reload_bit <= (2'(c) == RELOAD_CH) && wdata_ctrl.source_reload_bit;
                ctl[c].transfer_end_flag <= te_set ||
                    (ctl[c].transfer_end_flag && wdata_ctrl.transfer_end_flag);
            end else if (te_set) begin
                ctl[c].transfer_end_flag <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // external request edge latches
    // ------------------------------------------------------------
    for (genvar e = 0; e < CH_EXT; e++) begin : g_ext
        wire logic taken = accept && (pick == 2'(e));
        always_ff @(posedge mclk or negedge rst_n) begin
            if (!rst_n) begin
                req_prev[e] <= 1'b1;
                edge_pend[e] <= 1'b0;
            end else begin
                req_prev[e] <= transfer_request_n[e];
                // a new falling edge is needed to resume after a stop
                edge_pend[e] <= (req_prev[e] && !transfer_request_n[e]) ||
                                (edge_pend[e] && !taken && ctl[e].edge_detect);
            end
        end
    end

    // ------------------------------------------------------------
    // global flags, reload counter, register timing
    // ------------------------------------------------------------
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            master_transfer_enable <= 1'b0;
            nonmaskable_flag <= 1'b0;
            address_error_flag <= 1'b0;
            sa_orig <= ADDR_RESET;
        end else begin
            if (oper_wr) begin
                master_transfer_enable <= reg_wdata[OPER_MASTER];
            end
            nonmaskable_flag <= nmi_event ||
                (nonmaskable_flag && !(oper_wr && !reg_wdata[OPER_NMI]));
            address_error_flag <= addr_error_event ||
                (address_error_flag && !(oper_wr && !reg_wdata[OPER_AE]));
            if (reg_we && ch_space && reg_ch == RELOAD_CH && reg_sel == OFS_SRC) begin
                sa_orig <= reg_wdata;
            end
        end
    end

    wire logic rl_clear = !master_transfer_enable || !ctl[RELOAD_CH].channel_enable_bit ||
                          ctl[RELOAD_CH].transfer_end_flag || nonmaskable_flag ||
                          address_error_flag || standby;
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            rl_cnt <= 2'h0;
        end else if (rl_clear) begin
            rl_cnt <= 2'h0;
        end else if (unit_done && act == RELOAD_CH && act_ctl.source_reload_bit) begin
            rl_cnt <= rl_cnt + 2'h1;
        end
    end
    // a longword access loads five more busy clocks after the strobe so no engine cycle slips between halves
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            reg_busy <= 3'h0;
            reg_rdata <= 32'h0000_0000;
        end else begin
            if (reg_we || reg_re) begin
                reg_busy <= reg_long ? REG_LONG_LOAD : REG_WORD_LOAD;
            end else if (reg_busy != 3'h0) begin
                reg_busy <= reg_busy - 3'h1;
            end
            reg_rdata <= reg_re ? rd_mux : 32'h0000_0000;
        end
    end
    assign cpu_bus_cycle = (reg_busy != 3'h0) || reg_we || reg_re;

    // ------------------------------------------------------------
    // engine sequencing
    // ------------------------------------------------------------
    always_comb begin
        pick = 2'h0;
        for (int i = NUM_CH - 1; i >= 0; i--) begin
            if (pending[i]) begin
                pick = 2'(i);
            end
        end
    end
    always_comb begin
        next_state = state;
        next_act = act;
        accept = 1'b0;
        case (state)
            ST_IDLE: begin
                if (any_pend && !standby) begin
                    next_state = ST_LATENCY;
                    next_act = pick;
                    accept = (pick < 2'(CH_EXT)) && ctl[pick].ext_request;
                end
            end
            ST_LATENCY: begin
                if (lat == 2'h0 && !cpu_bus_cycle) begin
                    if (!act_ctl.single_addr) begin
                        next_state = ST_READ;
                    end else if (act_ctl.burst) begin
                        next_state = ST_DUMMY;
                    end else begin
                        next_state = ST_SINGLE;
                    end
                end
            end
            ST_DUMMY: begin
                if (last_cyc) begin
                    next_state = ST_SINGLE;
                end
            end
            ST_READ: begin
                if (last_cyc) begin
                    next_state = ST_WRITE;
                end
            end
            ST_WRITE, ST_SINGLE: begin
                if (unit_done) begin
                    if (!keep_going) begin
                        next_state = ST_IDLE;
                    end else if (act_ctl.single_addr) begin
                        next_state = ST_SINGLE;
                    end else begin
                        next_state = ST_READ;
                    end
                end
            end
            default: begin
                next_state = ST_IDLE;
            end
        endcase
        if (abort && state != ST_IDLE) begin
            next_state = ST_IDLE;
        end
    end
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            state <= ST_IDLE;
            act <= 2'h0;
            cyc <= 2'h0;
            lat <= 2'h0;
        end else begin
            state <= next_state;
            act <= next_act;
            cyc <= (next_state == state && bus_st && !last_cyc) ? cyc + 2'h1 : 2'h0;
            lat <= (state == ST_IDLE) ? LAT_LOAD : ((lat != 2'h0) ? lat - 2'h1 : lat);
        end
    end
    // sample for unit k+1 is taken one bus cycle before unit k, dummy not counted
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            pend_samp <= 1'b0;
            use_samp <= 1'b0;
        end else if (state == ST_LATENCY && lat == 2'h0) begin
            pend_samp <= act_req_low;
        end else if (state == ST_SINGLE && cyc == 2'h0) begin
            use_samp <= pend_samp;
            pend_samp <= act_req_low;
        end else if (state == ST_WRITE && cyc == 2'h0) begin
            use_samp <= act_req_low;
        end
    end
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            request_accepted_strobe <= '0;
        end else begin
            request_accepted_strobe <= accept ? CH_EXT'(1 << pick) : '0;
        end
    end

    // ------------------------------------------------------------
    // outputs to the pins and the memory bus
    // ------------------------------------------------------------
    wire logic ack_now = act_ext && ((state == ST_SINGLE) ||
                                     (state == ST_READ && !act_ctl.single_addr));
    assign transfer_acknowledge = ack_now ? CH_EXT'(1 << act[0]) : '0;
    assign dma_bus = '{active: bus_st, dummy: (state == ST_DUMMY),
                       wr: (state == ST_WRITE),
                       addr: (state == ST_WRITE) ? da[act] : sa[act]};

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    no_ack_dummy_a: assert property (@(posedge mclk) disable iff (!rst_n)
        (state == ST_DUMMY) |-> (transfer_acknowledge == '0))
        else $error("acknowledge during dummy cycle");
    dummy_no_count_a: assert property (@(posedge mclk) disable iff (!rst_n)
        (state == ST_DUMMY && !reg_we) |=> (cnt[act] == $past(cnt[act])))
        else $error("count changed in dummy cycle");
    req_latency_a: assert property (@(posedge mclk) disable iff (!rst_n)
        (state == ST_IDLE && next_state == ST_LATENCY && !abort)
        |=> (state == ST_LATENCY) [*2])
        else $error("transfer started before three cycles");
    strobe_pulse_a: assert property (@(posedge mclk) disable iff (!rst_n)
        (request_accepted_strobe != '0) |-> $past(state) == ST_IDLE)
        else $error("accept strobe outside first sample");
    count_dec_a: assert property (@(posedge mclk) disable iff (!rst_n)
        (unit_done && !reg_we) |=> (cnt[act] == $past(cnt[act]) - 32'h1))
        else $error("count not decremented");
    end_flag_a: assert property (@(posedge mclk) disable iff (!rst_n)
        $rose(te_vec[0]) |-> $past(unit_done && act == 2'h0 && cnt[0] == 32'h1))
        else $error("end flag set without count end");
    reload_addr_a: assert property (@(posedge mclk) disable iff (!rst_n)
        (reload_wrap && !reg_we) |=> (sa[RELOAD_CH] == $past(sa_orig)))
        else $error("source address not reloaded");
    reload_clear_a: assert property (@(posedge mclk) disable iff (!rst_n)
        (nonmaskable_flag || address_error_flag || standby) |=> (rl_cnt == 2'h0))
        else $error("reload counter not cleared");
    global_stop_a: assert property (@(posedge mclk) disable iff (!rst_n)
        (nonmaskable_flag && state == ST_IDLE) |=> (state == ST_IDLE))
        else $error("transfer started while stopped");
    master_abort_a: assert property (@(posedge mclk) disable iff (!rst_n)
        (!master_transfer_enable && state != ST_IDLE) |=> (state == ST_IDLE))
        else $error("master clear did not abort");
    long_access_a: assert property (@(posedge mclk) disable iff (!rst_n)
        ((reg_we || reg_re) && reg_long) |-> cpu_bus_cycle [*6])
        else $error("longword access shorter than six clocks");

endmodule

`default_nettype wire

// *** tb/dma_requester.sv ***
/* Requester model for channel 0 of the transfer controller.
   Assumes one mclk domain; go and edge_mode come from the bench. */
`timescale 1ns/1ps
`default_nettype none
module dma_requester (
    input wire logic mclk, // system clock
    input wire logic rst_n, // async reset, active low
    input wire logic go, // request wanted
    input wire logic edge_mode, // let go after accept
    input wire logic accepted, // accept strobe
    output logic request_n // request line, active low
);
    logic done;
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            done <= 1'b0;
        end else begin
            done <= go && (done || (edge_mode && accepted));
        end
    end
    // a new edge needs go dropped first
    assign request_n = !go || done;
endmodule
`default_nettype wire

// *** tb/dma_request_reload_and_termination_test.sv ***
/* Bench for dma_core: register timing, bursts, channel two reload.
   Assumes a 20 MHz mclk and the requester model on channel 0. */
`timescale 1ns/1ps
`default_nettype none
module dma_request_reload_and_termination_test;
    import dma_core_pkg::*;
    logic mclk = 0, rst_n = 0, reg_we = 0, reg_re = 0, reg_long = 0;
    logic go = 0, edge_mode = 0, nmi = 0, cyc, req_n;
    logic [7:0] reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0, reg_rdata, rdv;
    logic [1:0] ack, stb;
    logic [3:0] irq;
    dma_bus_s bus;
    int failures = 0, total_checks = 0, nd, na, ns, nc, nw;
    initial begin
        forever #25 mclk = ~mclk;
    end
    dma_core DUT (.mclk(mclk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_we(reg_we), .reg_re(reg_re), .reg_long(reg_long), .reg_rdata(reg_rdata),
        .cpu_bus_cycle(cyc), .transfer_request_n({1'b1, req_n}),
        .transfer_acknowledge(ack), .request_accepted_strobe(stb), .nmi_event(nmi),
        .addr_error_event(1'b0), .standby(1'b0), .dma_bus(bus),
        .transfer_end_interrupt(irq));
    dma_requester partner (.mclk(mclk), .rst_n(rst_n), .go(go), .edge_mode(edge_mode),
        .accepted(stb[0]), .request_n(req_n));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            failures++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_we <= 1'b1;
        @(posedge mclk);
        reg_we <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge mclk);
        reg_addr <= a;
        reg_re <= 1'b1;
        @(posedge mclk);
        reg_re <= 1'b0;
        #1 rdv = reg_rdata;
    endtask
    task automatic bus_len(input logic lng, input int exp);
        int n;
        n = 0;
        @(posedge mclk);
        reg_addr <= 8'h7C;
        reg_re <= 1'b1;
        reg_long <= lng;
        repeat (9) begin
            #1 n += int'(cyc);
            @(posedge mclk);
            reg_re <= 1'b0;
        end
        reg_long <= 1'b0;
        chk(32'(n), 32'(exp));
    endtask
    // ----------------------------------------
    // counts bus activity over 40 clocks; drops request once the channel 0 end interrupt is raised
    // ----------------------------------------
    task automatic watch();
        nd = 0;
        na = 0;
        ns = 0;
        nc = 0;
        nw = 0;
        repeat (40) begin
            @(posedge mclk);
            if (irq[0]) go <= 1'b0;
            #1;
            nd += int'(bus.dummy);
            na += int'(ack[0]);
            ns += int'(stb[0]);
            nc += int'(ack[0] & bus.dummy);
            nw += int'(bus.wr);
        end
    endtask
    task automatic finish_test();
        $display("checks=%0d failures=%0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    task automatic reg_timing();
        rd(8'h0C);
        chk(rdv, 32'h0);
        bus_len(1'b0, 3);
        bus_len(1'b1, 6);
    endtask
    task automatic level_burst();
        wr(8'h08, 32'h2);
        wr(8'h40, 32'h1);
        wr(8'h0C, 32'h6D);
        go <= 1'b1;
        watch();
        chk(32'(nd), 32'h2);
        chk(32'(na), 32'h4);
        chk(32'(nc), 32'h0);
        chk(32'(ns), 32'h1);
        chk({28'h0, irq}, 32'h1);
        rd(8'h0C);
        chk(rdv, 32'h6F);
    endtask
    task automatic edge_dual();
        wr(8'h08, 32'h3);
        wr(8'h0C, 32'h39);
        edge_mode <= 1'b1;
        go <= 1'b1;
        watch();
        chk(32'(ns), 32'h1);
        chk(32'(nd), 32'h0);
        chk(32'(na), 32'h6);
        chk(32'(nw), 32'h6);
        rd(8'h08);
        chk(rdv, 32'h0);
    endtask
    task automatic nmi_resume();
        @(posedge mclk);
        go <= 1'b0;
        wr(8'h08, 32'h4);
        wr(8'h0C, 32'h79);
        go <= 1'b1;
        for (int i = 0; i < 30 && !ack[0]; i++) begin
            @(posedge mclk);
            #1;
        end
        @(posedge mclk);
        nmi <= 1'b1;
        @(posedge mclk);
        nmi <= 1'b0;
        rd(8'h08);
        chk(rdv, 32'h3);
        rd(8'h40);
        chk(rdv, 32'h3);
        wr(8'h40, 32'h1);
        @(posedge mclk);
        go <= 1'b0;
        watch();
        chk(32'(na), 32'h0);
        @(posedge mclk);
        go <= 1'b1;
        watch();
        chk(32'(ns), 32'h1);
        chk(32'(nd), 32'h2);
        chk(32'(na), 32'h6);
        rd(8'h08);
        chk(rdv, 32'h0);
    endtask
    task automatic reload_run();
        wr(8'h20, 32'h1000);
        wr(8'h24, 32'h2000);
        wr(8'h28, 32'h8);
        wr(8'h2C, 32'hAA1);
        for (int i = 0; i < 20; i++) begin
            repeat (10) @(posedge mclk);
            rd(8'h28);
            if (rdv === 32'h0) break;
        end
        chk(rdv, 32'h0);
        rd(8'h20);
        chk(rdv, 32'h1000);
    endtask
    initial begin
        repeat (12) @(posedge mclk);
        rst_n <= 1'b1;
        reg_timing();
        level_burst();
        edge_dual();
        nmi_resume();
        reload_run();
        finish_test();
    end
endmodule
`default_nettype wire
